// >>> logic/adc_mode_clock_gpo_regs.sv
`timescale 1ns/1ns
`include "adc_regs_consts.svh"

// Contract
// - Mode 1000 runs gain calibration, then returns to idle by itself.
// - Mode 1001 alternates sequence conversion and standby by the duty ratio.
// - Mode 1010 converts one sequence per sync falling edge, then idles.
// - Mode 1011 converts one sequence per sync falling edge, then stands by.
// - Idle holds modulator and filter in reset, nothing else changes.
// - Clock select resets to 00: internal oscillator, clock pin not driven.
// - Clock select 01 runs internal oscillator and drives it on the pin.
// - Clock select 10 takes the main clock straight from the clock pin.
// - Clock select 11 divides the clock pin input by two.
// - Result register is read-only, resets to zero, holds latest conversion.
// - Output value bits 7..4 drive pins 4..1 when set as outputs.
// - Direction bits 3..0: zero keeps input function, one makes output.
// - Standby indicator enable makes pin 4 the standby output, top priority.
// - Interrupt routing to pin 2 overrides its other functions.
// - Pin control register resets to zero: all inputs, values low.
module adc_mode_clock_gpo_regs
    import adc_regs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic sclkPin,
    input wire logic csPinN,
    input wire logic mosiPin,
    output logic misoOut,
    output logic misoOe,
    input wire logic syncPinN,
    input wire logic oscClk,
    input wire logic clkPinIn,
    output logic clkPinOut,
    output logic clkPinOe,
    input wire logic intRequest,
    input wire logic convDone,
    input wire logic [15:0] convResult,
    input wire logic sequenceDone,
    input wire logic gainCalDone,
    output logic mainClk,
    output logic modulatorResetN,
    output logic standbyActive,
    output logic gainCalActive,
    output pin_drive_t pinDrive
);

    logic rstMeta_reg, rstSyncN_reg;
    logic [2:0] pinMeta_reg, pinSync_reg;
    logic syncLast_reg, extLast_reg, mainLast_reg;
    logic [15:0] ctrl_reg, ctrl_next;
    logic [15:0] pinCtrl_reg, pinCtrl_next;
    logic [15:0] result_reg, result_next;
    conv_state_t state_reg, state_next;
    logic [15:0] runCnt_reg, runCnt_next;
    logic [19:0] sleepCnt_reg, sleepCnt_next;
    logic divToggle_reg, divToggle_next;
    logic mainClk_next, clkPinOut_next, clkPinOe_next;
    logic modRstN_next, standby_next, gainCal_next;
    pin_drive_t pin_next;
    host_req_t hostReq;
    logic [15:0] readData;
    logic [3:0] curMode, newMode;
    logic [1:0] mclkSel;
    logic syncIn, oscIn, extIn, syncFall, extRise, mainTick;

    assign syncIn = pinSync_reg[2];
    assign oscIn = pinSync_reg[1];
    assign extIn = pinSync_reg[0];
    assign syncFall = ~syncIn & syncLast_reg;
    assign extRise = extIn & ~extLast_reg;
    assign mainTick = mainClk & ~mainLast_reg;
    assign curMode = ctrl_reg[`CTRL_MODE_LSB +: 4];
    assign newMode = hostReq.wdata[`CTRL_MODE_LSB +: 4];
    assign mclkSel = ctrl_reg[`CTRL_MCLK_LSB +: 2];

    function automatic logic isSyncMode(input logic [3:0] mode);
        return (mode == `MODE_SYNC_IDLE) || (mode == `MODE_SYNC_STBY);
    endfunction : isSyncMode

    function automatic conv_state_t entryState(input logic [3:0] mode);
        case (mode)
            `MODE_IDLE, `MODE_SYNC_IDLE: return ST_IDLE;
            `MODE_GAIN_CAL: return ST_GAIN_CAL;
            `MODE_SYNC_STBY: return ST_STANDBY;
            default: return ST_RUN;
        endcase
    endfunction : entryState

    function automatic logic [19:0] sleepSpan(input logic [15:0] run, input logic sixteenth);
        logic [19:0] mult;
        mult = sixteenth ? `SLEEP_MULT_SIXTEENTH : `SLEEP_MULT_QUARTER;
        return 20'(run) * mult;
    endfunction : sleepSpan

    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_reg <= 1'b0;
            rstSyncN_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSyncN_reg <= rstMeta_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncN_reg) begin
        if (!rstSyncN_reg) begin
            pinMeta_reg <= 3'h4;
            pinSync_reg <= 3'h4;
            syncLast_reg <= 1'b1;
            extLast_reg <= 1'b0;
            mainLast_reg <= 1'b0;
        end else if (clkEn) begin
            pinMeta_reg <= {syncPinN, oscClk, clkPinIn};
            pinSync_reg <= pinMeta_reg;
            syncLast_reg <= syncIn;
            extLast_reg <= extIn;
            mainLast_reg <= mainClk;
        end
    end

    // ****************************************************************
    // Host port
    // ****************************************************************
    spi_host_port u_host_port (
        .sys_clk(sys_clk),
        .rstSyncN(rstSyncN_reg),
        .clkEn(clkEn),
        .sclkPin(sclkPin),
        .csPinN(csPinN),
        .mosiPin(mosiPin),
        .readData(readData),
        .hostReq(hostReq),
        .misoOut(misoOut),
        .misoOe(misoOe)
    );

    always_comb begin
        readData = 16'h0000;
        if (hostReq.addr == `ADDR_CONTROL) begin
            readData = ctrl_reg;
        end else if (hostReq.addr == `ADDR_RESULT) begin
            readData = result_reg;
        end else if (hostReq.addr == `ADDR_PIN_CTRL) begin
            readData = pinCtrl_reg;
        end
    end

    // ****************************************************************
    // Registers and conversion sequencing
    // ****************************************************************
    always_comb begin
        ctrl_next = ctrl_reg;
        pinCtrl_next = pinCtrl_reg;
        result_next = result_reg;
        state_next = state_reg;
        runCnt_next = runCnt_reg;
        sleepCnt_next = sleepCnt_reg;
        if (convDone) begin
            result_next = convResult;
        end
        unique case (state_reg)
            ST_RUN: begin
                if (mainTick && runCnt_reg != 16'hFFFF) begin
                    runCnt_next = runCnt_reg + 16'h0001;
                end
                if (sequenceDone) begin
                    if (curMode == `MODE_DUTY) begin
                        state_next = ST_STANDBY;
                        sleepCnt_next = sleepSpan(runCnt_reg, ctrl_reg[`CTRL_PROP_BIT]);
                    end else if (curMode == `MODE_SYNC_IDLE) begin
                        state_next = ST_IDLE;
                    end else if (curMode == `MODE_SYNC_STBY) begin
                        state_next = ST_STANDBY;
                    end
                end
            end
            ST_STANDBY: begin
                if (curMode == `MODE_DUTY) begin
                    if (sleepCnt_reg == 20'h0_0000) begin
                        state_next = ST_RUN;
                    end else if (mainTick) begin
                        sleepCnt_next = sleepCnt_reg - 20'h0_0001;
                    end
                end else if (syncFall && isSyncMode(curMode)) begin
                    state_next = ST_RUN;
                end
            end
            ST_IDLE: begin
                if (syncFall && isSyncMode(curMode)) begin
                    state_next = ST_RUN;
                end
            end
            ST_GAIN_CAL: begin
                if (gainCalDone) begin
                    state_next = ST_IDLE;
                    ctrl_next[`CTRL_MODE_LSB +: 4] = `MODE_IDLE;
                end
            end
        endcase
        if (hostReq.wr && hostReq.addr == `ADDR_CONTROL) begin
            ctrl_next = hostReq.wdata & `CTRL_WRITE_MASK;
            if (newMode > `MODE_LAST_LEGAL) begin
                ctrl_next[`CTRL_MODE_LSB +: 4] = curMode;
            end else begin
                state_next = entryState(newMode);
                runCnt_next = 16'h0000;
            end
        end
        if (hostReq.wr && hostReq.addr == `ADDR_PIN_CTRL) begin
            pinCtrl_next = hostReq.wdata & `PIN_WRITE_MASK;
        end
        if (state_next == ST_RUN && state_reg != ST_RUN) begin
            runCnt_next = 16'h0000;
        end
    end

    // ****************************************************************
    // Clock selection and output stages
    // ****************************************************************
    always_comb begin
        divToggle_next = extRise ? ~divToggle_reg : divToggle_reg;
        unique case (mclkSel)
            `MCLK_INT_OFF, `MCLK_INT_OUT: mainClk_next = oscIn;
            `MCLK_EXT: mainClk_next = extIn;
            `MCLK_EXT_DIV2: mainClk_next = divToggle_reg;
        endcase
        clkPinOut_next = oscIn;
        clkPinOe_next = (mclkSel == `MCLK_INT_OUT);
        modRstN_next = !(state_next == ST_IDLE || state_next == ST_STANDBY);
        standby_next = (state_next == ST_STANDBY);
        gainCal_next = (state_next == ST_GAIN_CAL);
        pin_next.oe = pinCtrl_next[`PIN_DIR_LSB +: 4];
        pin_next.val = pinCtrl_next[`PIN_VAL_LSB +: 4];
        if (ctrl_next[`CTRL_STBY_IND_BIT]) begin
            pin_next.oe[3] = 1'b1;
            pin_next.val[3] = standby_next;
        end
        if (ctrl_next[`CTRL_INT_P2_BIT]) begin
            pin_next.oe[1] = 1'b1;
            pin_next.val[1] = intRequest;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncN_reg) begin
        if (!rstSyncN_reg) begin
            ctrl_reg <= `CTRL_RESET;
            pinCtrl_reg <= `PIN_RESET;
            result_reg <= `RESULT_RESET;
            state_reg <= ST_RUN;
            runCnt_reg <= 16'h0000;
            sleepCnt_reg <= 20'h0_0000;
            divToggle_reg <= 1'b0;
            mainClk <= 1'b0;
            clkPinOut <= 1'b0;
            clkPinOe <= 1'b0;
            modulatorResetN <= 1'b1;
            standbyActive <= 1'b0;
            gainCalActive <= 1'b0;
            pinDrive <= '0;
        end else if (clkEn) begin
            ctrl_reg <= ctrl_next;
            pinCtrl_reg <= pinCtrl_next;
            result_reg <= result_next;
            state_reg <= state_next;
            runCnt_reg <= runCnt_next;
            sleepCnt_reg <= sleepCnt_next;
            divToggle_reg <= divToggle_next;
            mainClk <= mainClk_next;
            clkPinOut <= clkPinOut_next;
            clkPinOe <= clkPinOe_next;
            modulatorResetN <= modRstN_next;
            standbyActive <= standby_next;
            gainCalActive <= gainCal_next;
            pinDrive <= pin_next;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstSyncN_reg);

    sequence s_sync_start;
        clkEn && syncFall && isSyncMode(curMode) && !hostReq.wr
            && state_reg != ST_RUN && state_reg != ST_GAIN_CAL;
    endsequence

    sequence s_seq_end(logic [3:0] mode);
        clkEn && state_reg == ST_RUN && sequenceDone && curMode == mode && !hostReq.wr;
    endsequence

    a_gain_cal_return: assert property (
        (clkEn && state_reg == ST_GAIN_CAL && gainCalDone && !hostReq.wr)
            |=> (state_reg == ST_IDLE && curMode == `MODE_IDLE && !gainCalActive))
        else $error("Gain calibration did not return to idle.");

    a_duty_to_standby: assert property (
        s_seq_end(`MODE_DUTY) |=> (standbyActive && !modulatorResetN))
        else $error("Duty cycle did not enter standby after a sequence.");

    a_sync_idle_seq: assert property (
        s_seq_end(`MODE_SYNC_IDLE) |=> (state_reg == ST_IDLE && !standbyActive))
        else $error("Single sequence did not end in idle.");

    a_sync_start_run: assert property (
        s_sync_start |=> (state_reg == ST_RUN && modulatorResetN))
        else $error("Sync falling edge did not start a sequence.");

    a_sync_stby_seq: assert property (
        s_seq_end(`MODE_SYNC_STBY) |=> standbyActive)
        else $error("Single sequence did not end in standby.");

    a_idle_held: assert property (
        (state_reg == ST_IDLE) |-> (!modulatorResetN && !standbyActive))
        else $error("Modulator not held in reset while idle.");

    a_clk_pin_drive: assert property (
        clkEn |=> (clkPinOe == ($past(mclkSel) == `MCLK_INT_OUT)))
        else $error("Clock pin enable does not follow clock selection.");

    a_ext_clock_path: assert property (
        (clkEn && mclkSel == `MCLK_EXT) |=> (mainClk == $past(extIn)))
        else $error("External clock not used directly.");

    a_ext_div_path: assert property (
        (clkEn && mclkSel == `MCLK_EXT_DIV2 && extRise) ##1 clkEn
            |=> (mainClk != $past(mainClk, 2)))
        else $error("Divided clock did not toggle on an input rise.");

    a_result_load: assert property (
        (clkEn && convDone) |=> (result_reg == $past(convResult)))
        else $error("Result register missed a conversion.");

    a_gpo_drive: assert property (
        (clkEn && !hostReq.wr) |=> (pinDrive.oe[0] == pinCtrl_reg[0]
            && pinDrive.val[0] == pinCtrl_reg[4] && pinDrive.oe[2] == pinCtrl_reg[2]))
        else $error("Pin drive does not follow pin control.");

    a_p4_standby: assert property (
        ctrl_reg[`CTRL_STBY_IND_BIT] && $past(clkEn)
            |-> (pinDrive.oe[3] && pinDrive.val[3] == standbyActive))
        else $error("Pin 4 does not show the standby state.");

    a_p2_interrupt: assert property (
        (clkEn && ctrl_reg[`CTRL_INT_P2_BIT] && !hostReq.wr)
            |=> (pinDrive.oe[1] && pinDrive.val[1] == $past(intRequest)))
        else $error("Pin 2 does not carry the interrupt.");

    a_reserved_zero: assert property (
        (pinCtrl_reg[15:8] == 8'h00) && (curMode <= `MODE_LAST_LEGAL))
        else $error("Reserved bits or mode code set.");

endmodule : adc_mode_clock_gpo_regs

// >>> logic/adc_regs_consts.svh
`ifndef ADC_REGS_CONSTS_SVH
`define ADC_REGS_CONSTS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_CONTROL 6'h01
`define ADDR_RESULT 6'h02
`define ADDR_PIN_CTRL 6'h03

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_MCLK_LSB 0
`define CTRL_MODE_LSB 2
`define CTRL_PROP_BIT 6
`define CTRL_STBY_IND_BIT 8
`define CTRL_INT_P2_BIT 9
`define PIN_DIR_LSB 0
`define PIN_VAL_LSB 4

// ****************************************************************
// Reset values and write masks
// ****************************************************************
`define CTRL_RESET 16'h0000
`define PIN_RESET 16'h0000
`define RESULT_RESET 16'h0000
`define CTRL_WRITE_MASK 16'h037F
`define PIN_WRITE_MASK 16'h00FF

// ****************************************************************
// Operating mode codes
// ****************************************************************
`define MODE_IDLE 4'h4
`define MODE_GAIN_CAL 4'h8
`define MODE_DUTY 4'h9
`define MODE_SYNC_IDLE 4'hA
`define MODE_SYNC_STBY 4'hB
`define MODE_LAST_LEGAL 4'hB

// ****************************************************************
// Main clock selection codes
// ****************************************************************
`define MCLK_INT_OFF 2'h0
`define MCLK_INT_OUT 2'h1
`define MCLK_EXT 2'h2
`define MCLK_EXT_DIV2 2'h3

// ****************************************************************
// Duty cycle standby multipliers and serial frame counts
// ****************************************************************
`define SLEEP_MULT_QUARTER 20'h0_0003
`define SLEEP_MULT_SIXTEENTH 20'h0_000F
`define CMD_LAST_BIT 5'h07
`define FRAME_LAST_BIT 5'h17
`define FRAME_BITS 5'h18

`endif

// >>> logic/adc_regs_pkg.sv
package adc_regs_pkg;

    typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_STANDBY, ST_GAIN_CAL} conv_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [15:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] val;
    } pin_drive_t;

endpackage : adc_regs_pkg

// >>> logic/spi_host_port.sv
`timescale 1ns/1ns
`include "adc_regs_consts.svh"

module spi_host_port
    import adc_regs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstSyncN,
    input wire logic clkEn,
    input wire logic sclkPin,
    input wire logic csPinN,
    input wire logic mosiPin,
    input wire logic [15:0] readData,
    output host_req_t hostReq,
    output logic misoOut,
    output logic misoOe
);

    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic sclkLast_reg;
    logic [4:0] bitCnt_reg, bitCnt_next;
    logic [23:0] shiftIn_reg, shiftIn_next;
    logic [15:0] shiftOut_reg, shiftOut_next;
    logic readFlag_reg, readFlag_next;
    logic miso_next, oe_next;
    host_req_t req_next;
    logic csN, sclk, mosi, sclkRise, sclkFall;

    assign csN = sync_reg[2];
    assign sclk = sync_reg[1];
    assign mosi = sync_reg[0];
    assign sclkRise = sclk & ~sclkLast_reg;
    assign sclkFall = ~sclk & sclkLast_reg;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            meta_reg <= 3'h6;
            sync_reg <= 3'h6;
            sclkLast_reg <= 1'b1;
        end else if (clkEn) begin
            meta_reg <= {csPinN, sclkPin, mosiPin};
            sync_reg <= meta_reg;
            sclkLast_reg <= sync_reg[1];
        end
    end

    // ****************************************************************
    // Frame engine
    // ****************************************************************
    always_comb begin
        bitCnt_next = bitCnt_reg;
        shiftIn_next = shiftIn_reg;
        shiftOut_next = shiftOut_reg;
        readFlag_next = readFlag_reg;
        miso_next = misoOut;
        oe_next = 1'b0;
        req_next = '0;
        if (csN) begin
            bitCnt_next = 5'h00;
            readFlag_next = 1'b0;
        end else begin
            if (hostReq.rd) begin
                readFlag_next = 1'b1;
                shiftOut_next = readData;
            end
            if (sclkRise && bitCnt_reg != `FRAME_BITS) begin
                shiftIn_next = {shiftIn_reg[22:0], mosi};
                bitCnt_next = bitCnt_reg + 5'h01;
                if (bitCnt_reg == `CMD_LAST_BIT && shiftIn_reg[6]) begin
                    req_next.rd = 1'b1;
                    req_next.addr = {shiftIn_reg[4:0], mosi};
                end
                if (bitCnt_reg == `FRAME_LAST_BIT && !shiftIn_reg[22]) begin
                    req_next.wr = 1'b1;
                    req_next.addr = shiftIn_reg[20:15];
                    req_next.wdata = {shiftIn_reg[14:0], mosi};
                end
            end
            if (sclkFall && readFlag_reg) begin
                miso_next = shiftOut_reg[15];
                shiftOut_next = {shiftOut_reg[14:0], 1'b0};
            end
            oe_next = readFlag_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            bitCnt_reg <= 5'h00;
            shiftIn_reg <= 24'h00_0000;
            shiftOut_reg <= 16'h0000;
            readFlag_reg <= 1'b0;
            misoOut <= 1'b0;
            misoOe <= 1'b0;
            hostReq <= '0;
        end else if (clkEn) begin
            bitCnt_reg <= bitCnt_next;
            shiftIn_reg <= shiftIn_next;
            shiftOut_reg <= shiftOut_next;
            readFlag_reg <= readFlag_next;
            misoOut <= miso_next;
            misoOe <= oe_next;
            hostReq <= req_next;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_miso_release: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        (csN && clkEn) |=> !misoOe)
        else $error("Data output still enabled after select went high.");

    a_write_frame_only: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        (hostReq.wr && $past(clkEn)) |-> $past(bitCnt_reg) == `FRAME_LAST_BIT)
        else $error("Write issued before a full frame.");

endmodule : spi_host_port

// >>> verification/testbench.sv
`timescale 1ns/1ns
`include "adc_regs_consts.svh"

module testbench;
    import adc_regs_pkg::*;

    logic sys_clk = 0, resetn = 0, sclkPin = 1, csPinN = 1, mosiPin = 0, syncPinN = 1;
    logic oscClk = 0, clkPinIn = 0, intRequest = 0, convDone = 0, sequenceDone = 0;
    logic gainCalDone = 0, prevMain = 0, clkEn = 1, oeMid = 0;
    logic [15:0] convResult = 16'h0000;
    logic misoOut, misoOe, clkPinOut, clkPinOe, mainClk, modulatorResetN;
    logic standbyActive, gainCalActive;
    pin_drive_t pinDrive;
    int fail_count = 0, check_count = 0, cycles = 0, rises = 0;

    adc_mode_clock_gpo_regs u_dut (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn),
        .sclkPin(sclkPin), .csPinN(csPinN), .mosiPin(mosiPin), .misoOut(misoOut),
        .misoOe(misoOe), .syncPinN(syncPinN), .oscClk(oscClk), .clkPinIn(clkPinIn),
        .clkPinOut(clkPinOut), .clkPinOe(clkPinOe), .intRequest(intRequest),
        .convDone(convDone), .convResult(convResult), .sequenceDone(sequenceDone),
        .gainCalDone(gainCalDone), .mainClk(mainClk), .modulatorResetN(modulatorResetN),
        .standbyActive(standbyActive), .gainCalActive(gainCalActive), .pinDrive(pinDrive));

    always #20 sys_clk = ~sys_clk;

    // The counter of main clock rises tells the selected source and divider apart.
    always @(posedge sys_clk) begin
        prevMain <= mainClk;
        cycles <= cycles + 1;
        if (mainClk === 1'b1 && prevMain === 1'b0) rises <= rises + 1;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    task end_sim;
        $display("Checks made: %0d, mismatches: %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    // ****************************************************************
    // Serial frame: command byte then 16 data bits, mode 3, MSB first.
    // ****************************************************************
    task xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {cmd, wd};
        rd = 16'h0000;
        csPinN = 0;
        cyc(4);
        for (int i = 23; i >= 0; i--) begin
            sclkPin = 0;
            mosiPin = sh[i];
            cyc(6);
            if (i < 16) rd[i] = misoOut;
            if (i == 8) oeMid = misoOe;
            sclkPin = 1;
            cyc(6);
        end
        csPinN = 1;
        cyc(8);
    endtask : xfer

    task wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] r;
        xfer({2'b00, a}, d, r);
    endtask : wr

    task rchk(input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] r;
        xfer({2'b10, a}, 16'h0000, r);
        check(r, exp);
    endtask : rchk

    task clkp(input int n, input logic ext);
        repeat (n) begin
            if (ext) clkPinIn = 1;
            else oscClk = 1;
            cyc(4);
            clkPinIn = 0;
            oscClk = 0;
            cyc(4);
        end
    endtask : clkp

    task seqEnd;
        sequenceDone = 1;
        cyc(1);
        sequenceDone = 0;
        cyc(4);
    endtask : seqEnd

    task syncPulse;
        syncPinN = 0;
        cyc(8);
        check(16'(modulatorResetN), 16'h0001);
        syncPinN = 1;
        cyc(4);
    endtask : syncPulse

    initial begin
        cyc(2);
        resetn = 1;
        cyc(8);
        rchk(`ADDR_CONTROL, 16'h0000);
        rchk(`ADDR_RESULT, 16'h0000);
        rchk(`ADDR_PIN_CTRL, 16'h0000);
        check(16'(pinDrive), 16'h0000);
        wr(`ADDR_PIN_CTRL, 16'hFFFF);
        rchk(`ADDR_PIN_CTRL, 16'h00FF);
        check(16'(pinDrive), 16'h00FF);
        wr(`ADDR_PIN_CTRL, 16'h0050);
        check(16'(pinDrive), 16'h0005);
        check(16'(oeMid), 16'h0000);
        wr(`ADDR_RESULT, 16'h1234);
        rchk(`ADDR_RESULT, 16'h0000);
        convResult = 16'hBEEF;
        convDone = 1;
        cyc(1);
        convDone = 0;
        rchk(`ADDR_RESULT, 16'hBEEF);
        check(16'(oeMid), 16'h0001);
        check(16'(misoOe), 16'h0000);
        // A result offered while the clock enable is low must not be taken.
        clkEn = 0;
        convResult = 16'h5A5A;
        convDone = 1;
        cyc(1);
        convDone = 0;
        clkEn = 1;
        rchk(`ADDR_RESULT, 16'hBEEF);
        for (int s = 0; s < 4; s++) begin
            wr(`ADDR_CONTROL, 16'(s));
            rises = 0;
            clkp(5, 1'b0);
            clkp(8, 1'b1);
            check(16'(rises), (s < 2) ? 16'h0005 : ((s == 2) ? 16'h0008 : 16'h0004));
            check(16'(clkPinOe), 16'(s == 1));
            if (s == 1) begin
                oscClk = 1;
                cyc(4);
                check(16'(clkPinOut), 16'h0001);
                oscClk = 0;
                cyc(4);
            end
        end
        wr(`ADDR_CONTROL, 16'h0028);
        check(16'(modulatorResetN), 16'h0000);
        syncPulse();
        seqEnd();
        check(16'(modulatorResetN), 16'h0000);
        wr(`ADDR_CONTROL, 16'h003D);
        rchk(`ADDR_CONTROL, 16'h0029);
        wr(`ADDR_CONTROL, 16'h012C);
        syncPulse();
        check(16'(standbyActive), 16'h0000);
        seqEnd();
        check(16'(standbyActive), 16'h0001);
        check({pinDrive.oe[3], pinDrive.val[3]}, 16'h0003);
        wr(`ADDR_CONTROL, 16'h0220);
        check(16'(gainCalActive), 16'h0001);
        intRequest = 1;
        cyc(4);
        check({pinDrive.oe[1], pinDrive.val[1]}, 16'h0003);
        intRequest = 0;
        gainCalDone = 1;
        cyc(1);
        gainCalDone = 0;
        cyc(4);
        check({pinDrive.oe[1], pinDrive.val[1]}, 16'h0002);
        check({gainCalActive, modulatorResetN}, 16'h0000);
        rchk(`ADDR_CONTROL, 16'h0210);
        wr(`ADDR_CONTROL, 16'h0024);
        check({standbyActive, modulatorResetN}, 16'h0001);
        clkp(2, 1'b0);
        seqEnd();
        check(16'(standbyActive), 16'h0001);
        clkp(5, 1'b0);
        check(16'(standbyActive), 16'h0001);
        clkp(3, 1'b0);
        check({standbyActive, modulatorResetN}, 16'h0001);
        // One tick of run at the one-sixteenth proportion gives fifteen ticks of standby.
        wr(`ADDR_CONTROL, 16'h0064);
        clkp(1, 1'b0);
        seqEnd();
        check(16'(standbyActive), 16'h0001);
        clkp(14, 1'b0);
        check(16'(standbyActive), 16'h0001);
        clkp(1, 1'b0);
        check({standbyActive, modulatorResetN}, 16'h0001);
        resetn = 0;
        cyc(2);
        check(16'(pinDrive), 16'h0000);
        resetn = 1;
        cyc(8);
        rchk(`ADDR_CONTROL, 16'h0000);
        rchk(`ADDR_PIN_CTRL, 16'h0000);
        rchk(`ADDR_RESULT, 16'h0000);
        end_sim();
    end
endmodule : testbench
